// [rtl/qep_encoder.sv]
// Top: quadrature decoder, position counter, interrupt status, velocity capture
`timescale 1ns/1ps
module qep_encoder
	import qep_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic enable_i,
	input wire logic phase_a_input_i,
	input wire logic phase_b_input_i,
	input wire logic index_i,
	input wire logic count_both_phases_i,
	input wire logic reset_on_index_mode_i,
	input wire logic clock_direction_input_mode_i,
	input wire logic phase_swap_select_i,
	input wire logic [QEP_POS_W-1:0] position_upper_bound_i,
	input wire logic position_load_i,
	input wire logic [QEP_POS_W-1:0] position_preload_value_i,
	input wire logic velocity_enable_set_i,
	input wire logic velocity_disable_set_i,
	input wire logic [QEP_DIV_W-1:0] velocity_predivide_select_i,
	input wire logic [QEP_VEL_W-1:0] velocity_window_ticks_i,
	input wire logic [QEP_INT_N-1:0] int_enable_set_i,
	input wire logic [QEP_INT_N-1:0] int_enable_clear_i,
	input wire logic [QEP_INT_N-1:0] int_clear_i,
	input wire logic masked_view_select_i,
	output logic [QEP_POS_W-1:0] position_o,
	output logic [QEP_VEL_W-1:0] velocity_o,
	output logic direction_rev_o,
	output logic error_o,
	output logic index_seen_o,
	output logic velocity_enabled_o,
	output logic [QEP_INT_N-1:0] int_status_o,
	output logic [QEP_INT_N-1:0] int_mask_o,
	output logic irq_o
);
	typedef struct packed {
		logic a;
		logic b;
		logic idx;
		logic [QEP_POS_W-1:0] pos;
		logic dir;
		logic err;
		logic idx_seen;
		logic vel_en;
		logic [QEP_INT_N-1:0] raw;
		logic [QEP_INT_N-1:0] mask;
	} qep_top_st_t;

	qep_top_st_t st_q;
	qep_top_st_t st_d;
	qep_pulse_if pulse_if ();
	logic [QEP_VEL_W-1:0] vel_val;
	logic win_done;
	logic ina;
	logic inb;
	logic ch_a;
	logic ch_b;
	logic step;
	logic rev;
	logic phase_err;
	logic idx_rise;
	logic [QEP_INT_N-1:0] ev;

	// ************************************************************
	// Decoder
	// ************************************************************
	always_comb begin
		ina = phase_swap_select_i ? phase_b_input_i : phase_a_input_i;
		inb = phase_swap_select_i ? phase_a_input_i : phase_b_input_i;
		ch_a = ina ^ st_q.a;
		ch_b = inb ^ st_q.b;
		step = 1'b0;
		rev = st_q.dir;
		phase_err = 1'b0;
		if (clock_direction_input_mode_i) begin
			// Clock on A, direction level on B
			step = ina & ~st_q.a;
			rev = inb;
		end else if (ch_a && ch_b) begin
			phase_err = 1'b1;
		end else if (ch_a) begin
			step = 1'b1;
			rev = ~(ina ^ inb);
		end else if (ch_b && count_both_phases_i) begin
			step = 1'b1;
			rev = ina ^ inb;
		end
		if (!enable_i) begin
			step = 1'b0;
			phase_err = 1'b0;
		end
		idx_rise = enable_i & index_i & ~st_q.idx;
	end

	assign pulse_if.step = step;
	assign pulse_if.dir_rev = rev;

	// ************************************************************
	// Position, direction and status
	// ************************************************************
	always_comb begin
		st_d = st_q;
		st_d.a = ina;
		st_d.b = inb;
		st_d.idx = index_i;
		ev = '0;
		if (step) begin
			st_d.dir = rev;
			ev[QEP_INT_DIR] = (rev != st_q.dir);
			if (rev) begin
				st_d.pos = (st_q.pos == '0) ? position_upper_bound_i : st_q.pos - 32'h1;
			end else begin
				st_d.pos = (st_q.pos >= position_upper_bound_i) ? '0 : st_q.pos + 32'h1;
			end
		end
		if (idx_rise) begin
			ev[QEP_INT_IDX] = 1'b1;
			st_d.idx_seen = 1'b1;
			if (reset_on_index_mode_i) begin
				st_d.pos = st_d.dir ? position_upper_bound_i : '0;
			end
		end
		if (position_load_i) begin
			st_d.pos = position_preload_value_i;
		end
		if (phase_err) begin
			st_d.err = 1'b1;
			ev[QEP_INT_ERR] = 1'b1;
		end
		ev[QEP_INT_TMR] = win_done;
		// Later write wins, so a simultaneous disable stops capture
		if (velocity_enable_set_i) begin
			st_d.vel_en = 1'b1;
		end
		if (velocity_disable_set_i) begin
			st_d.vel_en = 1'b0;
		end
		st_d.mask = (st_q.mask | int_enable_set_i) & ~int_enable_clear_i;
		// Set wins over clear so no event is lost
		st_d.raw = (st_q.raw & ~int_clear_i) | ev;
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			st_q <= '0;
		end else if (ce_i) begin
			st_q <= st_d;
		end
	end

	// ************************************************************
	// Velocity capture
	// ************************************************************
	qep_velocity u_vel (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.velocity_enable_i(st_q.vel_en),
		.velocity_predivide_select_i(velocity_predivide_select_i),
		.velocity_window_ticks_i(velocity_window_ticks_i),
		.pulse(pulse_if.snk),
		.velocity_o(vel_val),
		.window_done_o(win_done)
	);

	assign position_o = st_q.pos;
	assign velocity_o = vel_val;
	assign direction_rev_o = st_q.dir;
	assign error_o = st_q.err;
	assign index_seen_o = st_q.idx_seen;
	assign velocity_enabled_o = st_q.vel_en;
	assign int_mask_o = st_q.mask;
	assign int_status_o = masked_view_select_i ? (st_q.raw & st_q.mask) : st_q.raw;
	assign irq_o = |(st_q.raw & st_q.mask);
endmodule // qep_encoder

// [rtl/qep_pkg.sv]
// Package: widths, field positions, reset values and counts for the quadrature encoder block
package qep_pkg;
	localparam int QEP_POS_W = 32;
	localparam int QEP_VEL_W = 32;
	localparam int QEP_DIV_W = 3;
	localparam int QEP_INT_N = 4;
	// Interrupt status bit positions
	localparam int QEP_INT_ERR = 0;
	localparam int QEP_INT_DIR = 1;
	localparam int QEP_INT_TMR = 2;
	localparam int QEP_INT_IDX = 3;
	// Predivider codes: 0 is divide by one, 7 divide by 128
	localparam logic [QEP_DIV_W-1:0] QEP_DIV_BY_ONE = 3'h0;
	localparam logic [QEP_DIV_W-1:0] QEP_DIV_BY_MAX = 3'h7;
	localparam int QEP_PREDIV_W = 7;
	// Reset values
	localparam logic [QEP_POS_W-1:0] QEP_POS_RST = 32'h0000_0000;
	localparam logic [QEP_VEL_W-1:0] QEP_VEL_RST = 32'h0000_0000;
	localparam logic [QEP_INT_N-1:0] QEP_INT_RST = 4'h0;
	localparam logic [QEP_PREDIV_W-1:0] QEP_PREDIV_RST = 7'h00;
	localparam logic QEP_DIR_FWD = 1'b0;
	localparam logic QEP_DIR_REV = 1'b1;
endpackage

// [rtl/qep_pulse_if.sv]
// Interface: counted pulse stream from the decoder to the velocity path
`timescale 1ns/1ps
interface qep_pulse_if;
	logic step;
	logic dir_rev;
	modport src (output step, output dir_rev);
	modport snk (input step, input dir_rev);
endinterface

// [rtl/qep_velocity.sv]
// Velocity capture: predivider, tick window accumulator, result latch
`timescale 1ns/1ps
module qep_velocity
	import qep_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic velocity_enable_i,
	input wire logic [QEP_DIV_W-1:0] velocity_predivide_select_i,
	input wire logic [QEP_VEL_W-1:0] velocity_window_ticks_i,
	qep_pulse_if.snk pulse,
	output logic [QEP_VEL_W-1:0] velocity_o,
	output logic window_done_o
);
	typedef struct packed {
		logic [QEP_PREDIV_W-1:0] div;
		logic [QEP_VEL_W-1:0] timer;
		logic [QEP_VEL_W-1:0] acc;
		logic [QEP_VEL_W-1:0] vel;
		logic done;
	} qep_vel_st_t;

	qep_vel_st_t st_q;
	qep_vel_st_t st_d;
	logic div_pulse;
	logic [QEP_PREDIV_W-1:0] div_top;

	always_comb begin
		st_d = st_q;
		st_d.done = 1'b0;
		// Mask 2^n - 1 marks the wrap point of the predivider
		div_top = QEP_PREDIV_W'((8'h01 << velocity_predivide_select_i) - 8'h01);
		div_pulse = 1'b0;
		if (!velocity_enable_i) begin
			// Disabled: window restarts cleanly when capture comes back on
			st_d.div = QEP_PREDIV_RST;
			st_d.timer = QEP_VEL_RST;
			st_d.acc = QEP_VEL_RST;
		end else begin
			if (pulse.step) begin
				if (st_q.div >= div_top) begin
					st_d.div = QEP_PREDIV_RST;
					div_pulse = 1'b1;
				end else begin
					st_d.div = st_q.div + 7'h01;
				end
			end
			// A zero window count is illegal; it behaves as one tick
			if (st_q.timer + 32'h1 >= velocity_window_ticks_i) begin
				st_d.timer = QEP_VEL_RST;
				st_d.vel = st_q.acc + {31'h0, div_pulse};
				st_d.acc = QEP_VEL_RST;
				st_d.done = 1'b1;
			end else begin
				st_d.timer = st_q.timer + 32'h1;
				st_d.acc = st_q.acc + {31'h0, div_pulse};
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			st_q <= '0;
		end else if (ce_i) begin
			st_q <= st_d;
		end
	end

	assign velocity_o = st_q.vel;
	assign window_done_o = st_q.done;
endmodule // qep_velocity

// [sim/qep_encoder_checker.sv]
// Port-level assertions for the quadrature encoder top
`timescale 1ns/1ps
module qep_encoder_checker
	import qep_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic enable_i,
	input wire logic index_i,
	input wire logic position_load_i,
	input wire logic [QEP_POS_W-1:0] position_preload_value_i,
	input wire logic [QEP_INT_N-1:0] int_enable_clear_i,
	input wire logic masked_view_select_i,
	input wire logic [QEP_POS_W-1:0] position_o,
	input wire logic [QEP_VEL_W-1:0] velocity_o,
	input wire logic direction_rev_o,
	input wire logic error_o,
	input wire logic index_seen_o,
	input wire logic velocity_enabled_o,
	input wire logic [QEP_INT_N-1:0] int_status_o,
	input wire logic [QEP_INT_N-1:0] int_mask_o,
	input wire logic irq_o
);
	// ****
	// Checks; a frozen clock enable suspends them
	// ****
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i || !ce_i);
	sequence s_win_flag;
		##[1:2] int_status_o[QEP_INT_TMR];
	endsequence
	a_irq_or: assert property (masked_view_select_i |-> irq_o == |int_status_o)
		else $error("irq wrong");
	a_mask_clear: assert property (|int_enable_clear_i |=>
		!(int_mask_o & $past(int_enable_clear_i))) else $error("mask kept");
	a_err_sticky: assert property (error_o |=> error_o)
		else $error("error dropped");
	a_pos_load: assert property (position_load_i |=>
		position_o == $past(position_preload_value_i)) else $error("load lost");
	a_idx_seen: assert property (enable_i && $rose(index_i) |=> index_seen_o)
		else $error("index missed");
	a_vel_hold: assert property (!velocity_enabled_o |=> $stable(velocity_o))
		else $error("velocity moved");
	// Guarded by the previous reset level: a reset also moves these outputs
	a_win_event: assert property ($past(nrst_i) && !masked_view_select_i &&
		$changed(velocity_o) |-> s_win_flag) else $error("window flag missing");
	a_dir_event: assert property ($past(nrst_i) && !masked_view_select_i &&
		$changed(direction_rev_o) |-> ##[0:1] int_status_o[QEP_INT_DIR])
		else $error("direction flag missing");
endmodule // qep_encoder_checker
bind qep_encoder qep_encoder_checker u_chk (.*);

// [sim/qep_enc_model.sv]
// Encoder model: quadrature phases and index pulse
`timescale 1ns/1ps
module qep_enc_model (
	input wire logic clk_i,
	input wire logic step_i,
	input wire logic rev_i,
	input wire logic glitch_i,
	input wire logic index_req_i,
	output logic pha_o,
	output logic phb_o,
	output logic idx_o
);
	// ****
	// Gray stepping, both phases at once on glitch; phases move only on command
	// ****
	initial {pha_o, phb_o, idx_o} = 3'h0;
	always @(posedge clk_i) begin
		idx_o <= index_req_i;
		if (step_i && glitch_i) {pha_o, phb_o} <= ~{pha_o, phb_o};
		else if (step_i && ((pha_o == phb_o) ^ rev_i)) pha_o <= ~pha_o;
		else if (step_i) phb_o <= ~phb_o;
	end
endmodule // qep_enc_model

// [sim/qep_encoder_tb.sv]
// Self-checking bench for the quadrature encoder top
`timescale 1ns/1ps
module qep_encoder_tb
	import qep_pkg::*;
;
	logic clk, rst_n, stp, rev, glt, ixr, pa, pb, ix, cbp, rim, cdm, swp, ld, ven, vdis, mv;
	logic dr, err, seen, irq, ed, ve;
	logic [QEP_POS_W-1:0] bnd, pv, pos, ep;
	logic [QEP_VEL_W-1:0] vel, win;
	logic [QEP_DIV_W-1:0] dv;
	logic [QEP_INT_N-1:0] ies, iec, icl, sts, msk;
	int bad_count, checks;
	qep_enc_model u_enc (.clk_i(clk), .step_i(stp), .rev_i(rev), .glitch_i(glt),
		.index_req_i(ixr), .pha_o(pa), .phb_o(pb), .idx_o(ix));
	qep_encoder dut (.core_clk_i(clk), .nrst_i(rst_n), .ce_i(1'b1), .enable_i(1'b1),
		.phase_a_input_i(pa), .phase_b_input_i(pb), .index_i(ix), .count_both_phases_i(cbp),
		.reset_on_index_mode_i(rim), .clock_direction_input_mode_i(cdm),
		.phase_swap_select_i(swp), .position_upper_bound_i(bnd), .position_load_i(ld),
		.position_preload_value_i(pv), .velocity_enable_set_i(ven),
		.velocity_disable_set_i(vdis), .velocity_predivide_select_i(dv),
		.velocity_window_ticks_i(win), .int_enable_set_i(ies), .int_enable_clear_i(iec),
		.int_clear_i(icl), .masked_view_select_i(mv), .position_o(pos), .velocity_o(vel),
		.direction_rev_o(dr), .error_o(err), .index_seen_o(seen), .velocity_enabled_o(ve),
		.int_status_o(sts), .int_mask_o(msk), .irq_o(irq));
	// ****
	// Clock, compare, expectation
	// ****
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Returns whether the pin change is a counted step and moves the expected position
	function automatic logic ref_step(input logic oa, ob, na, nb);
		logic a0, b0, a1, b1, ca, cb, cnt, r;
		{a0, b0, a1, b1} = swp ? {ob, oa, nb, na} : {oa, ob, na, nb};
		ca = a0 ^ a1;
		cb = b0 ^ b1;
		cnt = cdm ? (!a0 && a1) : ((ca ^ cb) && (ca || cbp));
		r = cdm ? b1 : (ca ? a1 == b1 : a1 != b1);
		if (cnt) begin
			ed = r;
			ep = r ? (ep == '0 ? bnd : ep - 32'h1) : (ep >= bnd ? '0 : ep + 32'h1);
		end
		return cnt;
	endfunction
	task automatic step_once(input logic r, g);
		logic oa, ob, c;
		oa = pa;
		ob = pb;
		@(posedge clk);
		{stp, rev, glt} <= {1'b1, r, g};
		@(posedge clk);
		stp <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		c = ref_step(oa, ob, pa, pb);
		chk(pos, ep);
		if (c) chk(dr, ed);
	endtask
	// ****
	// Tests
	// ****
	initial begin
		{rst_n, stp, rev, glt, ixr, cbp, rim, cdm, swp, ld, ven, vdis, mv} = '0;
		{ies, iec, icl, dv, pv, ep, ed} = '0;
		bnd = 32'h0000_0009;
		win = 32'h0000_0258;
		bad_count = 0;
		checks = 0;
		void'($urandom(2));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (int m = 0; m < 5; m++) begin
			@(posedge clk);
			{cdm, swp, cbp} <= (m == 4) ? 3'h5 : {1'b0, m[1], m != 1};
			pv <= $urandom_range(0, 12);
			ld <= 1'b1;
			@(posedge clk);
			ld <= 1'b0;
			ep = pv;
			repeat (30) step_once($urandom_range(0, 1), 1'b0);
			$display("walk %0d done", m);
		end
		@(posedge clk);
		{cdm, swp, cbp, rim} <= 4'h3;
		for (int r = 0; r < 2; r++) begin
			step_once(r[0], 1'b0);
			@(posedge clk);
			ixr <= 1'b1;
			@(posedge clk);
			ixr <= 1'b0;
			repeat (2) @(posedge clk);
			@(negedge clk);
			ep = ed ? bnd : '0;
			chk(pos, ep);
			chk({seen, sts[QEP_INT_IDX]}, 2'h3);
		end
		@(posedge clk);
		{rim, ies, mv} <= {5'h08, 1'b1};
		@(posedge clk);
		ies <= '0;
		@(negedge clk);
		chk({irq, sts}, 5'h18);
		chk(msk, 4'h8);
		@(posedge clk);
		{iec, icl, mv} <= {8'h8f, 1'b0};
		@(posedge clk);
		{iec, icl} <= '0;
		@(negedge clk);
		chk({irq, sts}, 5'h00);
		chk(msk, 4'h0);
		$display("interrupt done");
		for (int n = 0; n < 8; n++) begin
			int s, k;
			s = $urandom_range(1, 130);
			@(posedge clk);
			dv <= n[2:0];
			@(posedge clk);
			ven <= 1'b1;
			@(posedge clk);
			ven <= 1'b0;
			@(negedge clk);
			chk(ve, 1'b1);
			repeat (s) step_once(1'b0, 1'b0);
			for (k = 0; k < 700 && sts[QEP_INT_TMR] !== 1'b1; k++) @(negedge clk);
			chk(sts[QEP_INT_TMR], 1'b1);
			if (k == 700) print_verdict();
			chk(vel, s >> n);
			@(posedge clk);
			{icl, vdis} <= 5'h09;
			@(posedge clk);
			{icl, vdis} <= '0;
			@(negedge clk);
			chk(ve, 1'b0);
			$display("velocity %0d done", n);
		end
		step_once(1'b0, 1'b1);
		chk({err, sts[QEP_INT_ERR]}, 2'h3);
		$display("error done");
		print_verdict();
	end
endmodule // qep_encoder_tb
